/* design/csr_rx_consts.svh */
// Constants of the console serial receiver: register numbers, bit positions, timing.
`ifndef CSR_RX_CONSTS_SVH
`define CSR_RX_CONSTS_SVH

// ----------------------------------------------------------------
// Internal processor register numbers
// ----------------------------------------------------------------
`define CSR_RX_CTL_NUM 6'h20
`define CSR_RX_DAT_NUM 6'h21
`define CSR_TX_CTL_NUM 6'h22
`define CSR_TX_DAT_NUM 6'h23

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define CSR_DONE_BIT 7
`define CSR_IE_BIT   6
`define CSR_ERR_BIT  15
`define CSR_OVR_BIT  14
`define CSR_FRM_BIT  13
`define CSR_BRK_BIT  11

// ----------------------------------------------------------------
// Reset values, interrupt and timing figures
// ----------------------------------------------------------------
`define CSR_DATA_RST   8'h00
`define CSR_IRQ_LEVEL  5'h14
`define CSR_IRQ_VECTOR 9'h0f8
`define CSR_BREAK_BITS 5'h14
`define CSR_BASE_BAUD  300
`define CSR_CLK_HZ     125000000

`endif

/* design/csr_rx_pkg.sv */
// Types shared by the console serial receiver.
package csr_rx_pkg;

    // Receiver deframing states.
    typedef enum logic [1:0] {
        CSR_IDLE,
        CSR_START,
        CSR_DATA,
        CSR_STOP
    } csr_state_t;

endpackage : csr_rx_pkg

/* design/csr_rx.sv */
// Console serial receiver: deframer, receive registers and interrupt request.
`timescale 1ns/10ps
`include "csr_rx_consts.svh"

module csr_rx
    import csr_rx_pkg::*;
#(
    parameter int CLK_HZ = `CSR_CLK_HZ,
    parameter int OVS    = 16
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        serial_in,
    input  wire logic [2:0]  baud_code,
    input  wire logic        dc_power_good,
    input  wire logic        cpu_halted,
    input  wire logic [5:0]  ipr_num,
    input  wire logic        ipr_rd,
    input  wire logic        ipr_wr,
    input  wire logic [31:0] ipr_wdata,
    output logic      [31:0] ipr_rdata,
    output logic             ipr_rvalid,
    output logic             rx_irq_req,
    output logic      [8:0]  rx_irq_vector
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        csr_state_t  st;
        logic [15:0] div;
        logic [3:0]  tick;
        logic [2:0]  bitn;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic        done;
        logic        ie;
        logic        ovr;
        logic        frm;
        logic        brk;
        logic [4:0]  spc;
        logic        armed;
        logic        irq;
        logic [8:0]  vec;
        logic [31:0] rdata;
        logic        rvalid;
        logic        pg_q;
    } csr_regs_t;

    csr_regs_t r_reg;
    csr_regs_t r_next;

    logic tk;
    logic rd_dat;
    logic pg_clr;
    logic complete;
    logic brk_fire;
    logic [4:0] stop_spc;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Reload of the oversampling divider for a baud code.
    function automatic logic [15:0] csr_div(input logic [2:0] code);
        int rate;
        rate = (`CSR_BASE_BAUD << code) * OVS;
        return 16'(CLK_HZ / rate - 1);
    endfunction : csr_div

    // Space bit count after one sample, saturating at the top.
    function automatic logic [4:0] csr_spc(input logic [4:0] c, input logic d);
        if (d) begin
            return 5'h00;
        end
        return (c == 5'h1f) ? c : c + 5'h01;
    endfunction : csr_spc

    // Event decodes shared by the next-state logic and the checks.
    assign tk       = (r_reg.div == 16'h0000);
    assign rd_dat   = ipr_rd && (ipr_num == `CSR_RX_DAT_NUM);
    assign pg_clr   = r_reg.pg_q && !dc_power_good && cpu_halted;
    assign complete = (r_reg.st == CSR_STOP) && tk && (r_reg.tick == 4'(OVS - 1));
    assign stop_spc = csr_spc(r_reg.spc, serial_in);
    assign brk_fire = complete && r_reg.armed && !serial_in
                      && (stop_spc >= `CSR_BREAK_BITS);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Register port, deframer and flag updates; later writes win.
    always_comb begin
        r_next = r_reg;
        r_next.pg_q = dc_power_good;
        r_next.div = tk ? csr_div(baud_code) : r_reg.div - 16'h0001;
        // A mark on the line ends any run of space bits and re-arms break.
        if (serial_in) begin
            r_next.spc = 5'h00;
            r_next.armed = 1'b1;
        end
        // Register reads; unused bits stay zero.
        r_next.rvalid = ipr_rd && (ipr_num == `CSR_RX_CTL_NUM || rd_dat);
        r_next.rdata = 32'h0000_0000;
        if (ipr_rd && ipr_num == `CSR_RX_CTL_NUM) begin
            r_next.rdata[`CSR_DONE_BIT] = r_reg.done;
            r_next.rdata[`CSR_IE_BIT] = r_reg.ie;
        end
        if (rd_dat) begin
            r_next.rdata[7:0] = r_reg.data;
            r_next.rdata[`CSR_ERR_BIT] = r_reg.ovr | r_reg.frm;
            r_next.rdata[`CSR_OVR_BIT] = r_reg.ovr;
            r_next.rdata[`CSR_FRM_BIT] = r_reg.frm;
            r_next.rdata[`CSR_BRK_BIT] = r_reg.brk;
            r_next.done = 1'b0;
            r_next.ovr = 1'b0;
            r_next.frm = 1'b0;
            r_next.brk = 1'b0;
        end
        // Only the enable bit of the control register is writable.
        if (ipr_wr && ipr_num == `CSR_RX_CTL_NUM) begin
            r_next.ie = ipr_wdata[`CSR_IE_BIT];
        end
        // Deframer.
        unique case (r_reg.st)
            CSR_IDLE: begin
                if (!serial_in) begin
                    r_next.st = CSR_START;
                    r_next.tick = 4'h0;
                    r_next.div = csr_div(baud_code);
                end
            end
            CSR_START: begin
                if (tk) begin
                    if (r_reg.tick == 4'(OVS / 2 - 1)) begin
                        r_next.tick = 4'h0;
                        r_next.bitn = 3'h0;
                        if (serial_in) begin
                            r_next.st = CSR_IDLE;
                        end else begin
                            r_next.st = CSR_DATA;
                            r_next.spc = csr_spc(r_reg.spc, 1'b0);
                        end
                    end else begin
                        r_next.tick = r_reg.tick + 4'h1;
                    end
                end
            end
            CSR_DATA: begin
                if (tk) begin
                    if (r_reg.tick == 4'(OVS - 1)) begin
                        r_next.tick = 4'h0;
                        r_next.shift = {serial_in, r_reg.shift[7:1]};
                        if (!serial_in) begin
                            r_next.spc = csr_spc(r_reg.spc, 1'b0);
                        end
                        if (r_reg.bitn == 3'h7) begin
                            r_next.st = CSR_STOP;
                        end else begin
                            r_next.bitn = r_reg.bitn + 3'h1;
                        end
                    end else begin
                        r_next.tick = r_reg.tick + 4'h1;
                    end
                end
            end
            CSR_STOP: begin
                if (tk) begin
                    r_next.tick = r_reg.tick + 4'h1;
                end
                // One stop bit sampled; all error flags refreshed together.
                if (complete) begin
                    r_next.st = CSR_IDLE;
                    r_next.tick = 4'h0;
                    r_next.spc = stop_spc;
                    r_next.data = r_reg.shift;
                    r_next.done = 1'b1;
                    r_next.ovr = r_reg.done && !rd_dat;
                    r_next.frm = !serial_in;
                    r_next.brk = brk_fire;
                    if (brk_fire) begin
                        r_next.armed = 1'b0;
                    end
                end
            end
        endcase
        // Power-good loss while halted clears the software flags.
        if (pg_clr) begin
            r_next.done = 1'b0;
            r_next.ie = 1'b0;
            r_next.ovr = 1'b0;
            r_next.frm = 1'b0;
            r_next.brk = 1'b0;
        end
        r_next.irq = r_next.ie && r_next.done;
        r_next.vec = r_next.irq ? `CSR_IRQ_VECTOR : 9'h000;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------

    // Synchronous reset to the quiet, idle line state.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r_reg <= '0;
            r_reg.st <= CSR_IDLE;
            r_reg.data <= `CSR_DATA_RST;
            r_reg.armed <= 1'b1;
            r_reg.pg_q <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state flops.
    assign ipr_rdata     = r_reg.rdata;
    assign ipr_rvalid    = r_reg.rvalid;
    assign rx_irq_req    = r_reg.irq;
    assign rx_irq_vector = r_reg.vec;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // A data read with no new character clears done.
    property p_done_clr;
        rd_dat && !complete |=> !r_reg.done;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");

    // Request and vector follow enable and done.
    property p_irq;
        r_reg.ie && r_reg.done |-> rx_irq_req && rx_irq_vector == 9'h0f8;
    endproperty
    a_irq: assert property (p_irq) else $error("irq request wrong");

    // Control reads show only bits 7 and 6.
    property p_rsv;
        ipr_rd && ipr_num == 6'h20 |=> ipr_rvalid && ipr_rdata[31:8] == 24'h0
            && ipr_rdata[5:0] == 6'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");

    // Error summary equals overrun or framing on a data read.
    property p_err;
        ipr_rd && ipr_num == 6'h21 |=> ipr_rdata[15] == (ipr_rdata[14] | ipr_rdata[13])
            && ipr_rdata[12] == 1'b0;
    endproperty
    a_err: assert property (p_err) else $error("error summary wrong");

    // An unread character replaced sets overrun.
    property p_ovr;
        complete && r_reg.done && !rd_dat && !pg_clr |=> r_reg.ovr;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");

    // Framing flag mirrors the stop-bit sample.
    property p_frm;
        complete && !pg_clr |=> r_reg.frm == !$past(serial_in);
    endproperty
    a_frm: assert property (p_frm) else $error("framing flag wrong");

    // Error flags hold between characters.
    property p_hold;
        !complete && !rd_dat && !pg_clr |=> $stable({r_reg.ovr, r_reg.frm, r_reg.brk});
    endproperty
    a_hold: assert property (p_hold) else $error("error flags moved");

    // A break sets break and framing, then disarms.
    property p_brk;
        brk_fire && !pg_clr |=> r_reg.brk && r_reg.frm && !r_reg.armed;
    endproperty
    a_brk: assert property (p_brk) else $error("break handling wrong");

    // Loss of power-good while halted clears the flags.
    property p_pg;
        pg_clr |=> !r_reg.done && !r_reg.ie && !r_reg.brk;
    endproperty
    a_pg: assert property (p_pg) else $error("flags not cleared");

    // A false start returns to idle.
    property p_false_start;
        r_reg.st == CSR_START && tk && r_reg.tick == 4'(OVS / 2 - 1) && serial_in
            |=> r_reg.st == CSR_IDLE;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start kept");

    // Main scenarios.
    c_char: cover property (complete ##1 r_reg.done);
    c_ovr: cover property (complete && r_reg.done && !rd_dat);
    c_brk: cover property (brk_fire);
    c_irq: cover property (rx_irq_req ##1 rd_dat);

endmodule : csr_rx

/* tb/csr_term.sv */
// Terminal model that drives characters onto the receiver's serial line.
`timescale 1ns/10ps
module csr_term (
    input  wire logic core_clk,
    output logic      line
);
    // The line rests at mark between frames.
    initial line = 1'b1;

    // Sends start, eight data bits LSB first, then one stop bit of the given level.
    task automatic send(input logic [7:0] ch, input logic stop, input int bitc);
        logic [9:0] f;
        f = {stop, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line = f[i];
            repeat (bitc) @(posedge core_clk);
            #1;
        end
        line = 1'b1;
        repeat (2 * bitc) @(posedge core_clk);
        #1;
    endtask : send

    // Holds the line at space for a number of bit times, then returns to mark.
    task automatic space(input int bits, input int bitc);
        line = 1'b0;
        repeat (bits * bitc) @(posedge core_clk);
        #1;
        line = 1'b1;
        repeat (2 * bitc) @(posedge core_clk);
        #1;
    endtask : space
endmodule : csr_term

/* tb/csr_rx_tb_top.sv */
// Self-checking testbench of the console serial receiver.
`timescale 1ns/10ps
`include "csr_rx_consts.svh"
module csr_rx_tb_top;
    logic        core_clk;
    logic        resetn;
    logic        serial_in;
    logic [2:0]  baud_code;
    logic        dc_power_good;
    logic        cpu_halted;
    logic [5:0]  ipr_num;
    logic        ipr_rd;
    logic        ipr_wr;
    logic [31:0] ipr_wdata;
    logic [31:0] ipr_rdata;
    logic        ipr_rvalid;
    logic        rx_irq_req;
    logic [8:0]  rx_irq_vector;
    int          failures;
    int          tests_run;
    int          bitc;

    // At this clock figure code 4 gives 128-cycle bits and code 7 a tick every cycle.
    csr_rx #(.CLK_HZ(614400), .OVS(16)) dut (
        .core_clk(core_clk), .resetn(resetn), .serial_in(serial_in),
        .baud_code(baud_code), .dc_power_good(dc_power_good), .cpu_halted(cpu_halted),
        .ipr_num(ipr_num), .ipr_rd(ipr_rd), .ipr_wr(ipr_wr), .ipr_wdata(ipr_wdata),
        .ipr_rdata(ipr_rdata), .ipr_rvalid(ipr_rvalid), .rx_irq_req(rx_irq_req),
        .rx_irq_vector(rx_irq_vector)
    );

    csr_term term (.core_clk(core_clk), .line(serial_in));

    // Clock of 8 ns period.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", nm, exp, got);
            failures++;
        end
    endtask : chk

    // Reads a register number and compares the answer; unmapped numbers give no answer.
    task automatic rdc(input logic [5:0] n, input logic [31:0] exp);
        logic vld;
        vld = (n == `CSR_RX_CTL_NUM) || (n == `CSR_RX_DAT_NUM);
        ipr_num = n;
        ipr_rd = 1'b1;
        @(posedge core_clk);
        #1;
        ipr_rd = 1'b0;
        chk("ipr_rvalid", {31'h0, vld}, {31'h0, ipr_rvalid});
        chk((n == `CSR_RX_DAT_NUM) ? "rx_data" : "rx_ctl", exp, ipr_rdata);
        // One idle edge keeps back-to-back calls from toggling the strobe in one step.
        @(posedge core_clk);
        #1;
    endtask : rdc

    // Writes one register number.
    task automatic wr(input logic [5:0] n, input logic [31:0] d);
        ipr_num = n;
        ipr_wdata = d;
        ipr_wr = 1'b1;
        @(posedge core_clk);
        #1;
        ipr_wr = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : wr

    // Waits out the character that follows a long space, then reads the data register.
    task automatic drain(input logic [31:0] exp);
        repeat (12 * bitc) @(posedge core_clk);
        #1;
        rdc(`CSR_RX_DAT_NUM, exp);
    endtask : drain

    // Reset state and an unmapped number.
    task automatic t_reset;
        rdc(`CSR_RX_CTL_NUM, 32'h0);
        rdc(`CSR_RX_DAT_NUM, 32'h0);
        rdc(`CSR_TX_CTL_NUM, 32'h0);
        chk("rx_irq_req", 32'h0, {31'h0, rx_irq_req});
        $display("t_reset done");
    endtask : t_reset

    // One character with interrupt, register write masks and read clearing.
    task automatic t_char;
        wr(`CSR_RX_CTL_NUM, 32'hffffffff);
        rdc(`CSR_RX_CTL_NUM, 32'h40);
        term.send(8'ha5, 1'b1, bitc);
        rdc(`CSR_RX_CTL_NUM, 32'hc0);
        chk("rx_irq_req", 32'h1, {31'h0, rx_irq_req});
        chk("rx_irq_vector", 32'hf8, {23'h0, rx_irq_vector});
        wr(`CSR_RX_DAT_NUM, 32'hffffffff);
        wr(`CSR_RX_CTL_NUM, 32'hffffffbf);
        rdc(`CSR_RX_CTL_NUM, 32'h80);
        chk("rx_irq_req", 32'h0, {31'h0, rx_irq_req});
        rdc(`CSR_RX_DAT_NUM, 32'ha5);
        rdc(`CSR_RX_CTL_NUM, 32'h0);
        $display("t_char done");
    endtask : t_char

    // Overrun alone, framing alone, and flags held until read.
    task automatic t_errors;
        term.send(8'h5a, 1'b1, bitc);
        term.send(8'h3c, 1'b1, bitc);
        rdc(`CSR_RX_CTL_NUM, 32'h80);
        rdc(`CSR_RX_DAT_NUM, 32'hc03c);
        term.send(8'h81, 1'b0, bitc);
        rdc(`CSR_RX_DAT_NUM, 32'ha081);
        rdc(`CSR_RX_DAT_NUM, 32'h81);
        $display("t_errors done");
    endtask : t_errors

    // Break detection, re-arming only after mark, glitch start refused.
    task automatic t_break;
        term.space(20, bitc);
        rdc(`CSR_RX_DAT_NUM, 32'he800);
        drain(32'hff);
        term.space(30, bitc);
        rdc(`CSR_RX_DAT_NUM, 32'he000);
        drain(32'hff);
        term.space(20, bitc);
        rdc(`CSR_RX_DAT_NUM, 32'he800);
        rdc(`CSR_RX_CTL_NUM, 32'h0);
        drain(32'hff);
        // A space shorter than half a bit must not start a character.
        term.space(1, bitc / 4);
        rdc(`CSR_RX_CTL_NUM, 32'h0);
        $display("t_break done");
    endtask : t_break

    // Power-good loss clears flags only while the processor is halted.
    task automatic t_power;
        wr(`CSR_RX_CTL_NUM, 32'h40);
        term.send(8'h77, 1'b0, bitc);
        dc_power_good = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rdc(`CSR_RX_CTL_NUM, 32'hc0);
        dc_power_good = 1'b1;
        cpu_halted = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        dc_power_good = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rdc(`CSR_RX_CTL_NUM, 32'h0);
        rdc(`CSR_RX_DAT_NUM, 32'h77);
        dc_power_good = 1'b1;
        cpu_halted = 1'b0;
        $display("t_power done");
    endtask : t_power

    // Every baud code, bit time halving with each step from 2048 cycles.
    task automatic t_baud;
        for (int c = 0; c < 8; c++) begin
            baud_code = c[2:0];
            bitc = 2048 >> c;
            term.send(8'h30 + c[7:0], 1'b1, bitc);
            rdc(`CSR_RX_DAT_NUM, {24'h0, 8'h30 + c[7:0]});
        end
        baud_code = 3'h4;
        bitc = 128;
        $display("t_baud done");
    endtask : t_baud

    // Reset, then the scenarios in turn.
    initial begin
        failures = 0;
        tests_run = 0;
        bitc = 128;
        resetn = 1'b0;
        baud_code = 3'h4;
        dc_power_good = 1'b1;
        cpu_halted = 1'b0;
        ipr_num = 6'h0;
        ipr_rd = 1'b0;
        ipr_wr = 1'b0;
        ipr_wdata = 32'h0;
        repeat (5) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_char();
        t_errors();
        t_break();
        t_power();
        t_baud();
        end_sim();
    end

    // Watchdog beyond the roughly 71000 cycles the scenarios need.
    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        end_sim();
    end
endmodule : csr_rx_tb_top
